// File: sslh_host_model.sv
// Host model: sends and takes 8N1 characters
`timescale 1ns/10ps
`default_nettype none
module sslh_host_model #(
  parameter int BIT_CYC = 1040 // Cycles a bit at 9600
) (
  input  wire logic       ref_clk_i,     // Clock
  input  wire logic       txd_i,         // From device
  output logic            rxd_o = 1'h1,  // To device, idle high
  output logic            got_o = 1'h0,  // Byte pulse
  output logic      [7:0] byte_o         // Byte taken
);
  // =====
  // Send one character, start bit and lsb first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk_i);
    end
  endtask : send
  // Sample each character at bit centres
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk_i);
      byte_o[i] <= txd_i;
    end
    repeat (BIT_CYC) @(posedge ref_clk_i);
    got_o <= txd_i;
    @(posedge ref_clk_i);
    got_o <= 1'h0;
  end
endmodule : sslh_host_model
`default_nettype wire

// File: sslh_monitor.sv
// Port checker of the serial link port
`timescale 1ns/10ps
`default_nettype none
module sslh_monitor (
  input wire logic       ref_clk_i, // Clock
  input wire logic       rst_i,     // Reset
  input wire logic       psel_i,    // Select
  input wire logic       penable_i, // Enable
  input wire logic [7:0] paddr_i,   // Address
  input wire logic       pready_o,  // Ready
  input wire logic       pslverr_o, // Error
  input wire logic       txd_o,     // Line out
  input wire logic       irq_o      // Interrupt
);
  localparam int BMIN = 1038;
  localparam int LMAX = 9362;
  logic [15:0] hi_ff;
  logic [15:0] lo_ff;
  logic        acc;
  assign acc = psel_i && penable_i && !pready_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // =====
  // Saturating run lengths of the line
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_ff <= 16'h0000;
      lo_ff <= 16'h0000;
    end else begin
      hi_ff <= txd_o ? hi_ff + {15'h0000, ~&hi_ff} : 16'h0000;
      lo_ff <= txd_o ? 16'h0000 : lo_ff + {15'h0000, ~&lo_ff};
    end
  end
  a_ready_late: assert property (acc |=> pready_o) else $error("ready missing");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  a_err_unmapped: assert property (acc && (paddr_i > 8'h1c || paddr_i[1:0] != 2'h0)
    |=> pslverr_o) else $error("no error on bad address");
  a_err_mapped: assert property (acc && paddr_i <= 8'h1c && paddr_i[1:0] == 2'h0
    |=> !pslverr_o) else $error("error on good address");
  a_low_run_max: assert property (lo_ff <= 16'(LMAX)) else $error("line low too long");
  a_high_run_min: assert property ($fell(txd_o) |-> hi_ff >= 16'(BMIN))
    else $error("high run short");
  a_low_run_min: assert property ($rose(txd_o) |-> lo_ff >= 16'(BMIN))
    else $error("low run short");
  c_err: cover property (pslverr_o);
  c_frame: cover property ($fell(txd_o));
  c_irq: cover property (irq_o);
endmodule : sslh_monitor
bind sslh_top sslh_monitor mon_u (.ref_clk_i, .rst_i, .psel_i, .penable_i, .paddr_i,
  .pready_o, .pslverr_o, .txd_o, .irq_o);
`default_nettype wire

// File: sslh_pkg.sv
// Constants, register map and types of the servo serial link handshake port
// Operation
// - Every character: one start bit, eight data bits, no parity, one stop bit.
// - Two-bit baud code: 0 gives 2400, 1 gives 4800, 2 gives 9600 bit/s.
// - Baud and module ID changes take effect only at next control power-on.
// - Module ID is configurable from 1 to 15 and names this unit.
// - Host and driver are wired point to point; nobody else shares the line.
// - A side with a block to send first transmits request byte 05h.
// - A side able to accept a block answers with ready byte 04h.
// - Transmit mode starts only after sending request and receiving ready.
// - Receive mode starts after receiving request and answering ready.
// - A complete, correct block is answered with acknowledge byte 06h.
// - A faulty block is answered with negative acknowledge byte 15h.
// - A block is faulty on checksum failure or inter-character timeout.
// - First byte N gives N plus 3 more bytes; all bytes must sum to zero.
// - Sender retries from the request byte on timeout or any non-acknowledge reply.
// - Inter-character timeout programmable 1 to 255 tenths of a second; expiry gives 15h.
// - On simultaneous requests the slave yields and enters receive mode; code ignores a request arriving while its own is still being sent.
package sslh_pkg;
  // ==========================================================================
  // Timing
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          OS_RATE     = 16;
  localparam logic [15:0] DIV_2400    = 16'(CLK_HZ / (OS_RATE * 2400));
  localparam logic [15:0] DIV_4800    = 16'(CLK_HZ / (OS_RATE * 4800));
  localparam logic [15:0] DIV_9600    = 16'(CLK_HZ / (OS_RATE * 9600));
  localparam int          T_UNIT_MS   = 100;
  localparam int          TENTH_CYC   = CLK_HZ / 1000 * T_UNIT_MS;
  localparam logic [11:0] SEC_TENTHS  = 12'h00a;
  localparam logic [8:0]  BLK_EXTRA   = 9'h004;
  // ==========================================================================
  // Control bytes
  localparam logic [7:0]  C_REQ       = 8'h05;
  localparam logic [7:0]  C_RDY       = 8'h04;
  localparam logic [7:0]  C_ACK       = 8'h06;
  localparam logic [7:0]  C_NAK       = 8'h15;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0]  A_SETUP     = 8'h00;
  localparam logic [7:0]  A_PROTO     = 8'h04;
  localparam logic [7:0]  A_TXDATA    = 8'h08;
  localparam logic [7:0]  A_CMD       = 8'h0c;
  localparam logic [7:0]  A_STATUS    = 8'h10;
  localparam logic [7:0]  A_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  A_IRQ_MASK  = 8'h18;
  localparam logic [7:0]  A_RXDATA    = 8'h1c;
  // Field positions
  localparam int          F_BAUD      = 0;
  localparam int          F_ID        = 4;
  localparam int          F_T1        = 0;
  localparam int          F_T2        = 8;
  localparam int          F_RTY       = 16;
  localparam int          F_MASTER    = 20;
  localparam int          F_SEND      = 0;
  localparam int          F_CLRBUF    = 1;
  // Reset values
  localparam logic [1:0]  RST_BAUD    = 2'h2;
  localparam logic [3:0]  RST_ID      = 4'h1;
  localparam logic [7:0]  RST_T1      = 8'h05;
  localparam logic [7:0]  RST_T2      = 8'h0a;
  localparam logic [3:0]  RST_RTY     = 4'h1;
  // Interrupt bits: rx ok, rx bad, tx ok, tx fail
  localparam int          N_EV        = 4;
  // ==========================================================================
  // Link states
  typedef enum logic [5:0] {
    S_IDLE     = 6'h01,
    S_WAIT_RDY = 6'h02,
    S_TX_BLK   = 6'h04,
    S_WAIT_ACK = 6'h08,
    S_RX_BLK   = 6'h10,
    S_RX_REPLY = 6'h20
  } sslh_state_e;
endpackage : sslh_pkg

// File: sslh_rx.sv
// Serial character receiver, 16x oversampled
`timescale 1ns/10ps
`default_nettype none
module sslh_rx (
  input  wire logic       ref_clk_i, // System clock
  input  wire logic       rst_i,     // Async reset, high
  input  wire logic       os_tick_i, // Oversample tick
  input  wire logic       rxd_i,     // Serial line in
  output logic      [7:0] byte_o,    // Received byte
  output logic            vld_o      // Byte valid pulse
);
  logic       s1_ff;
  logic       s2_ff;
  logic       busy_ff;
  logic [3:0] ph_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic       vld_ff;
  wire        ph_end = (ph_ff == ((bit_ff == 4'h0) ? 4'h7 : 4'hf));

  // ==========================================================================
  // Two-stage line synchroniser
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= rxd_i;
      s2_ff <= s1_ff;
    end
  end

  // Start detect, mid-bit sampling, stop check
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      ph_ff   <= 4'h0;
      bit_ff  <= 4'h0;
      sh_ff   <= 8'h00;
      vld_ff  <= 1'b0;
    end else begin
      vld_ff <= 1'b0;
      if (!busy_ff) begin
        busy_ff <= ~s2_ff;
        ph_ff   <= 4'h0;
        bit_ff  <= 4'h0;
      end else if (os_tick_i) begin
        ph_ff <= ph_end ? 4'h0 : ph_ff + 4'h1;
        if (ph_end) begin
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff == 4'h0) begin
            busy_ff <= ~s2_ff;                 // False start aborts
          end else if (bit_ff <= 4'h8) begin
            sh_ff <= {s2_ff, sh_ff[7:1]};      // LSB first
          end else begin
            busy_ff <= 1'b0;
            vld_ff  <= s2_ff;                  // Needs a high stop bit
          end
        end
      end
    end
  end

  assign byte_o = sh_ff;
  assign vld_o  = vld_ff;
endmodule : sslh_rx
`default_nettype wire

// File: sslh_top.sv
// Servo serial link port: APB registers, handshake engine, block buffers
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sslh_top #(
  parameter int TENTH_CYC = sslh_pkg::TENTH_CYC        // Cycles in 0.1 s
) (
  input  wire logic        ref_clk_i,     // System clock, 10 MHz
  input  wire logic        rst_i,         // Async reset, high
  input  wire logic        psel_i,        // APB select
  input  wire logic        penable_i,     // APB enable
  input  wire logic        pwrite_i,      // APB write
  input  wire logic [7:0]  paddr_i,       // APB byte address
  input  wire logic [31:0] pwdata_i,      // APB write data
  output logic      [31:0] prdata_o,      // APB read data
  output logic             pready_o,      // APB ready
  output logic             pslverr_o,     // APB error, unmapped
  input  wire logic        ctrl_pwr_on_i, // Control power applied
  input  wire logic        rxd_i,         // Serial in
  output logic             txd_o,         // Serial out
  output logic             irq_o          // Interrupt, high
);
  localparam int N_EV_W = sslh_pkg::N_EV;

  sslh_pkg::sslh_state_e state_ff, nxt_state;

  logic [1:0]  set_baud_ff;
  logic [3:0]  set_id_ff;
  logic [1:0]  act_baud_ff;
  logic [3:0]  act_id_ff;
  logic        boot_ff;
  logic        pw1_ff, pw2_ff, pw3_ff;
  logic [7:0]  t1_ff;
  logic [7:0]  t2_ff;
  logic [3:0]  rty_ff;
  logic        master_ff;
  logic [15:0] os_cnt_ff;
  logic [23:0] pre_ff;
  logic [11:0] tmr_ff, nxt_tmr;
  logic        send_ff, nxt_send;
  logic [8:0]  idx_ff, nxt_idx;
  logic [7:0]  sum_ff, nxt_sum;
  logic        bad_ff, nxt_bad;
  logic [3:0]  try_ff, nxt_try;
  logic        go_ff, nxt_go;
  logic [7:0]  gob_ff, nxt_gob;
  logic [N_EV_W-1:0] ev;
  logic        rxw;
  logic [7:0]  tx_buf_ff [256];
  logic [7:0]  rx_buf_ff [256];
  logic [7:0]  tx_wp_ff;
  logic [7:0]  rx_rp_ff;
  logic [8:0]  rx_cnt_ff;
  logic [3:0]  irq_stat_ff, irq_mask_ff, nxt_stat;
  logic        irq_ff;
  logic        pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic        tx_busy;
  logic        txd;
  logic [7:0]  rx_byte;
  logic        rx_vld;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] baud_div(input logic [1:0] code);
    unique case (code)
      2'h1:    baud_div = sslh_pkg::DIV_4800;
      2'h2:    baud_div = sslh_pkg::DIV_9600;
      default: baud_div = sslh_pkg::DIV_2400;
    endcase
  endfunction : baud_div

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= sslh_pkg::A_RXDATA);
  endfunction : addr_ok

  // ==========================================================================
  // APB decode
  wire        acc     = psel_i & penable_i & ~pready_ff;
  wire        hit     = addr_ok(paddr_i);
  wire        wr      = acc & pwrite_i & hit;
  wire        rd      = acc & ~pwrite_i & hit;
  wire        wr_set  = wr & (paddr_i == sslh_pkg::A_SETUP);
  wire        wr_pro  = wr & (paddr_i == sslh_pkg::A_PROTO);
  wire        wr_txd  = wr & (paddr_i == sslh_pkg::A_TXDATA) & ~send_ff;
  wire        wr_cmd  = wr & (paddr_i == sslh_pkg::A_CMD);
  wire        wr_ist  = wr & (paddr_i == sslh_pkg::A_IRQ_STAT);
  wire        wr_msk  = wr & (paddr_i == sslh_pkg::A_IRQ_MASK);
  wire        rd_rxd  = rd & (paddr_i == sslh_pkg::A_RXDATA);
  wire        cmd_go  = wr_cmd & pwdata_i[sslh_pkg::F_SEND];
  wire        cmd_clr = wr_cmd & pwdata_i[sslh_pkg::F_CLRBUF] & ~send_ff;
  wire [3:0]  wr_id   = pwdata_i[sslh_pkg::F_ID +: 4];
  wire [31:0] rd_mux  =
      (paddr_i == sslh_pkg::A_SETUP)    ? {24'h0, set_id_ff, 2'h0, set_baud_ff} :
      (paddr_i == sslh_pkg::A_PROTO)    ? {11'h0, master_ff, rty_ff, t2_ff, t1_ff} :
      (paddr_i == sslh_pkg::A_STATUS)   ? {act_id_ff, act_baud_ff, rx_cnt_ff,
                                           send_ff, 10'h0, state_ff} :
      (paddr_i == sslh_pkg::A_IRQ_STAT) ? {28'h0, irq_stat_ff} :
      (paddr_i == sslh_pkg::A_IRQ_MASK) ? {28'h0, irq_mask_ff} :
      (paddr_i == sslh_pkg::A_RXDATA)   ? {24'h0, rx_buf_ff[rx_rp_ff]} :
      (paddr_i == sslh_pkg::A_TXDATA)   ? {24'h0, tx_wp_ff} : 32'h0;

  // Registered APB answer, one wait state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~hit;
      prdata_ff  <= rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================================================
  // Settings; line settings are latched only at control power-on
  wire pwr_edge = pw2_ff & ~pw3_ff;
  wire reload   = ~boot_ff | pwr_edge;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pw1_ff      <= 1'b0;
      pw2_ff      <= 1'b0;
      pw3_ff      <= 1'b0;
      boot_ff     <= 1'b0;
      set_baud_ff <= sslh_pkg::RST_BAUD;
      set_id_ff   <= sslh_pkg::RST_ID;
      act_baud_ff <= sslh_pkg::RST_BAUD;
      act_id_ff   <= sslh_pkg::RST_ID;
    end else begin
      pw1_ff  <= ctrl_pwr_on_i;
      pw2_ff  <= pw1_ff;
      pw3_ff  <= pw2_ff;
      boot_ff <= 1'b1;
      if (wr_set) begin
        set_baud_ff <= pwdata_i[sslh_pkg::F_BAUD +: 2];
        if (wr_id != 4'h0) begin
          set_id_ff <= wr_id;
        end
      end
      if (reload) begin
        act_baud_ff <= set_baud_ff;
        act_id_ff   <= set_id_ff;
      end
    end
  end

  // Protocol parameters, live; zero timeouts ignored
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t1_ff     <= sslh_pkg::RST_T1;
      t2_ff     <= sslh_pkg::RST_T2;
      rty_ff    <= sslh_pkg::RST_RTY;
      master_ff <= 1'b0;
    end else if (wr_pro) begin
      if (pwdata_i[sslh_pkg::F_T1 +: 8] != 8'h0) begin
        t1_ff <= pwdata_i[sslh_pkg::F_T1 +: 8];
      end
      if (pwdata_i[sslh_pkg::F_T2 +: 8] != 8'h0) begin
        t2_ff <= pwdata_i[sslh_pkg::F_T2 +: 8];
      end
      rty_ff    <= pwdata_i[sslh_pkg::F_RTY +: 4];
      master_ff <= pwdata_i[sslh_pkg::F_MASTER];
    end
  end

  // ==========================================================================
  // Oversample divider and 0.1 s prescaler
  wire os_tick = (os_cnt_ff == 16'h0);
  wire tenth   = (pre_ff == 24'h0);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      os_cnt_ff <= 16'h0;
      pre_ff    <= 24'h0;
    end else begin
      os_cnt_ff <= os_tick ? baud_div(act_baud_ff) - 16'h1 : os_cnt_ff - 16'h1;
      pre_ff    <= tenth ? 24'(TENTH_CYC - 1) : pre_ff - 24'h1;
    end
  end

  sslh_rx u_rx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .os_tick_i (os_tick),
    .rxd_i     (rxd_i),
    .byte_o    (rx_byte),
    .vld_o     (rx_vld)
  );

  sslh_tx u_tx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .os_tick_i (os_tick),
    .go_i      (go_ff),
    .data_i    (gob_ff),
    .busy_o    (tx_busy),
    .txd_o     (txd)
  );

  // ==========================================================================
  // Handshake engine
  wire        tx_free = ~tx_busy & ~go_ff;
  wire        tmo     = (tmr_ff == 12'h0);
  wire [11:0] t1_tn   = {4'h0, t1_ff};
  wire [11:0] t2_tn   = 12'(t2_ff * sslh_pkg::SEC_TENTHS);
  wire [8:0]  tx_len  = {1'b0, tx_buf_ff[0]} + sslh_pkg::BLK_EXTRA;
  wire [7:0]  n_byte  = (idx_ff == 9'h0) ? rx_byte : rx_buf_ff[0];
  wire [8:0]  rx_len  = {1'b0, n_byte} + sslh_pkg::BLK_EXTRA;
  wire        last_tr = (try_ff >= rty_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr   = (tenth && !tmo) ? tmr_ff - 12'h1 : tmr_ff;
    nxt_send  = send_ff | cmd_go;
    nxt_idx   = idx_ff;
    nxt_sum   = sum_ff;
    nxt_bad   = bad_ff;
    nxt_try   = try_ff;
    nxt_go    = 1'b0;
    nxt_gob   = gob_ff;
    ev        = 4'h0;
    rxw       = 1'b0;
    unique case (state_ff)
      sslh_pkg::S_IDLE: begin
        if (rx_vld && rx_byte == sslh_pkg::C_REQ && tx_free) begin
          nxt_go    = 1'b1;
          nxt_gob   = sslh_pkg::C_RDY;
          nxt_state = sslh_pkg::S_RX_BLK;
          nxt_idx   = 9'h0;
          nxt_sum   = 8'h0;
          nxt_tmr   = t2_tn;
        end else if (send_ff && tx_free) begin
          nxt_go    = 1'b1;
          nxt_gob   = sslh_pkg::C_REQ;
          nxt_state = sslh_pkg::S_WAIT_RDY;
          nxt_tmr   = t2_tn;
        end
      end
      sslh_pkg::S_WAIT_RDY: begin
        if (rx_vld && rx_byte == sslh_pkg::C_RDY) begin
          nxt_state = sslh_pkg::S_TX_BLK;
          nxt_idx   = 9'h0;
        end else if (rx_vld && rx_byte == sslh_pkg::C_REQ && !master_ff && tx_free) begin
          nxt_go    = 1'b1;
          nxt_gob   = sslh_pkg::C_RDY;
          nxt_state = sslh_pkg::S_RX_BLK;
          nxt_idx   = 9'h0;
          nxt_sum   = 8'h0;
          nxt_tmr   = t2_tn;
        end else if (tmo) begin
          nxt_state = sslh_pkg::S_IDLE;
          nxt_try   = last_tr ? 4'h0 : try_ff + 4'h1;
          nxt_send  = ~last_tr;
          ev[3]     = last_tr;
        end
      end
      sslh_pkg::S_TX_BLK: begin
        if (tx_free && idx_ff == tx_len) begin
          nxt_state = sslh_pkg::S_WAIT_ACK;
          nxt_tmr   = t2_tn;
        end else if (tx_free) begin
          nxt_go  = 1'b1;
          nxt_gob = tx_buf_ff[idx_ff[7:0]];
          nxt_idx = idx_ff + 9'h1;
        end
      end
      sslh_pkg::S_WAIT_ACK: begin
        if (rx_vld && rx_byte == sslh_pkg::C_ACK) begin
          nxt_state = sslh_pkg::S_IDLE;
          nxt_try   = 4'h0;
          nxt_send  = 1'b0;
          ev[2]     = 1'b1;
        end else if (rx_vld || tmo) begin
          nxt_state = sslh_pkg::S_IDLE;
          nxt_try   = last_tr ? 4'h0 : try_ff + 4'h1;
          nxt_send  = ~last_tr;
          ev[3]     = last_tr;
        end
      end
      sslh_pkg::S_RX_BLK: begin
        if (rx_vld) begin
          rxw     = 1'b1;
          nxt_idx = idx_ff + 9'h1;
          nxt_sum = sum_ff + rx_byte;
          nxt_tmr = t1_tn;
          if (idx_ff + 9'h1 == rx_len) begin
            nxt_state = sslh_pkg::S_RX_REPLY;
            nxt_bad   = (sum_ff + rx_byte) != 8'h0;
          end
        end else if (tmo) begin
          nxt_state = sslh_pkg::S_RX_REPLY;
          nxt_bad   = 1'b1;
        end
      end
      sslh_pkg::S_RX_REPLY: begin
        if (tx_free) begin
          nxt_go    = 1'b1;
          nxt_gob   = bad_ff ? sslh_pkg::C_NAK : sslh_pkg::C_ACK;
          nxt_state = sslh_pkg::S_IDLE;
          nxt_bad   = 1'b0;
          ev[1]     = bad_ff;
          ev[0]     = ~bad_ff;
        end
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= sslh_pkg::S_IDLE;
      tmr_ff   <= 12'h0;
      send_ff  <= 1'b0;
      idx_ff   <= 9'h0;
      sum_ff   <= 8'h0;
      bad_ff   <= 1'b0;
      try_ff   <= 4'h0;
      go_ff    <= 1'b0;
      gob_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
      send_ff  <= nxt_send;
      idx_ff   <= nxt_idx;
      sum_ff   <= nxt_sum;
      bad_ff   <= nxt_bad;
      try_ff   <= nxt_try;
      go_ff    <= nxt_go;
      gob_ff   <= nxt_gob;
    end
  end

  // ==========================================================================
  // Block buffers, flip-flop storage
  always_ff @(posedge ref_clk_i) begin
    if (wr_txd) begin
      tx_buf_ff[tx_wp_ff] <= pwdata_i[7:0];
    end
    if (rxw) begin
      rx_buf_ff[idx_ff[7:0]] <= rx_byte;
    end
  end

  // Buffer pointers and received length
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_wp_ff  <= 8'h0;
      rx_rp_ff  <= 8'h0;
      rx_cnt_ff <= 9'h0;
    end else begin
      tx_wp_ff  <= cmd_clr ? 8'h0 : tx_wp_ff + {7'h0, wr_txd};
      rx_rp_ff  <= rxw && idx_ff == 9'h0 ? 8'h0 : rx_rp_ff + {7'h0, rd_rxd};
      rx_cnt_ff <= rxw ? nxt_idx : rx_cnt_ff;
    end
  end

  // ==========================================================================
  // Interrupts: sticky, write one to clear, set wins
  always_comb begin
    nxt_stat = (irq_stat_ff & ~(wr_ist ? pwdata_i[3:0] : 4'h0)) | ev;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_stat;
      irq_mask_ff <= wr_msk ? pwdata_i[3:0] : irq_mask_ff;
      irq_ff      <= |(nxt_stat & (wr_msk ? pwdata_i[3:0] : irq_mask_ff));
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign txd_o     = txd;       // Point-to-point line
  assign irq_o     = irq_ff;
endmodule : sslh_top
`default_nettype wire

// File: sslh_top_tb.sv
// Bench of the serial link port
`timescale 1ns/10ps
`default_nettype none
module sslh_top_tb;
  logic        ref_clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        psel_i = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i = 1'h0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        pwr = 1'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rxd, txd, irq, got;
  logic [7:0]  gbyte;
  logic [31:0] r = 32'h0000_5e68;
  logic [32:0] eq_apb[$];
  logic [7:0]  eq_ser[$];
  int          errors = 0;
  int          n_compared = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  sslh_top #(.TENTH_CYC(100)) dut_u (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ctrl_pwr_on_i(pwr), .rxd_i(rxd), .txd_o(txd), .irq_o(irq));
  sslh_host_model host_u (.ref_clk_i, .txd_i(txd), .rxd_o(rxd), .got_o(got), .byte_o(gbyte));
  // =====
  // Shared tasks
  task automatic check(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : check
  function automatic logic [7:0] rnd();
    r ^= r << 13;
    r ^= r >> 17;
    r ^= r << 5;
    return r[7:0];
  endfunction : rnd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    eq_apb.push_back(e);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'h1);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask : apb
  task automatic wait_got();
    do begin
      @(posedge ref_clk_i);
    end while (got !== 1'h1);
  endtask : wait_got
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Compare finished transfers and bytes from the device
  always @(posedge ref_clk_i) begin
    if (pready === 1'h1 && psel_i && penable_i)
      check({pslverr, prdata}, eq_apb.size() != 0 ? eq_apb.pop_front() : 33'hx);
    if (got === 1'h1)
      check({25'h0, gbyte}, {25'h0, eq_ser.size() != 0 ? eq_ser.pop_front() : 8'hxx});
  end
  // Watchdog
  initial begin
    repeat (130000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [7:0] a;
    logic [7:0] c;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    @(posedge ref_clk_i);
    apb(1'h0, sslh_pkg::A_SETUP, 32'h0, 33'h12);
    apb(1'h0, sslh_pkg::A_PROTO, 32'h0, 33'h1_0a05);
    apb(1'h1, sslh_pkg::A_SETUP, 32'h52, 33'h0);
    apb(1'h0, sslh_pkg::A_STATUS, 32'h0, 33'h1800_0001);
    pwr <= 1'h1;
    repeat (8) @(posedge ref_clk_i);
    apb(1'h0, sslh_pkg::A_STATUS, 32'h0, 33'h5800_0001);
    a = rnd();
    apb(1'h1, {1'h1, a[4:0], 2'h0}, {24'h0, rnd()}, 33'h1_0000_0000);
    apb(1'h1, sslh_pkg::A_IRQ_MASK, 32'h1, 33'h0);
    apb(1'h1, sslh_pkg::A_PROTO, 32'h1_ffff, 33'h0);
    eq_ser.push_back(sslh_pkg::C_RDY);
    host_u.send(sslh_pkg::C_REQ);
    wait_got();
    c = rnd();
    eq_ser.push_back(sslh_pkg::C_ACK);
    host_u.send(8'h00);
    host_u.send(8'h05);
    host_u.send(c);
    host_u.send(8'h00 - 8'h05 - c);
    wait_got();
    check({32'h0, irq}, 33'h1);
    apb(1'h0, sslh_pkg::A_IRQ_STAT, 32'h0, 33'h1);
    apb(1'h1, sslh_pkg::A_IRQ_STAT, 32'h1, 33'h0);
    apb(1'h1, sslh_pkg::A_PROTO, 32'h1_0101, 33'h0);
    eq_ser.push_back(sslh_pkg::C_RDY);
    eq_ser.push_back(sslh_pkg::C_NAK);
    host_u.send(sslh_pkg::C_REQ);
    wait_got();
    wait_got();
    check({32'h0, irq}, 33'h0);
    apb(1'h0, sslh_pkg::A_IRQ_STAT, 32'h0, 33'h2);
    check({32'h0, eq_ser.size() == 0 && eq_apb.size() == 0}, 33'h1);
    tally_and_finish();
  end
endmodule : sslh_top_tb
`default_nettype wire

// File: sslh_tx.sv
// Serial character transmitter, 8N1
`timescale 1ns/10ps
`default_nettype none
module sslh_tx (
  input  wire logic       ref_clk_i, // System clock
  input  wire logic       rst_i,     // Async reset, high
  input  wire logic       os_tick_i, // Oversample tick
  input  wire logic       go_i,      // Start pulse
  input  wire logic [7:0] data_i,    // Byte to send
  output logic            busy_o,    // Character in flight
  output logic            txd_o      // Serial line out
);
  logic [10:0] sh_ff;
  logic [3:0] ph_ff;
  logic [3:0] cnt_ff;
  logic       busy_ff;

  // ==========================================================================
  // Frame shifter: start, eight data, stop, line idles high
  // Start bit waits for the next tick, so every bit is a full 16 ticks
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_ff   <= 11'h7ff;
      ph_ff   <= 4'h0;
      cnt_ff  <= 4'h0;
      busy_ff <= 1'b0;
    end else if (go_i && !busy_ff) begin
      sh_ff   <= {1'b1, data_i, 1'b0, 1'b1};
      ph_ff   <= 4'hf;
      cnt_ff  <= 4'h0;
      busy_ff <= 1'b1;
    end else if (busy_ff && os_tick_i) begin
      ph_ff <= ph_ff + 4'h1;
      if (ph_ff == 4'hf) begin
        sh_ff   <= {1'b1, sh_ff[10:1]};
        cnt_ff  <= cnt_ff + 4'h1;
        busy_ff <= (cnt_ff != 4'ha);
      end
    end
  end

  assign busy_o = busy_ff;
  assign txd_o  = sh_ff[0];
endmodule : sslh_tx
`default_nettype wire
